// *** pkg/sch_pkg.sv ***
// Shared constants and types of the system command handler
package sch_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int PARAM_W = 32;                   // Width of one parameter set image
  localparam int CNT_W   = 16;                   // Width of each write-cycle counter

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_KHZ    = 50000;             // System clock rate in kHz
  localparam int REBOOT_MS  = 1000;              // Reboot hold time in ms
  localparam int REBOOT_CYC = REBOOT_MS * CLK_KHZ; // Reboot hold time in cycles

  // ****************************************
  // Values after reset and fixed codes
  // ****************************************
  localparam logic [PARAM_W-1:0] PARAM_DEFAULT = 32'h0000_0000; // Firmware default set
  localparam logic [7:0] ERR_NONE   = 8'h00;     // No error pending
  localparam logic [7:0] ERR_NVM    = 8'h10;     // Nonvolatile access failed
  localparam logic [7:0] ERR_ARG    = 8'h11;     // Argument out of range
  localparam logic [7:0] ERR_AMP    = 8'h1d;     // Amplifier shutdown, error 29
  localparam logic signed [7:0] ARG_ERASE = 8'shff; // Minus one argument
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000; // Counter value after reset

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    SCH_SAVE, SCH_RESTORE, SCH_RESET, SCH_AMP, SCH_ERRQ
  } sch_cmd_t;                                   // Decoded system command

  typedef enum logic [1:0] {
    SCH_RSP_OK, SCH_RSP_ERR, SCH_RSP_VAL
  } sch_rsp_t;                                   // Reply kind

  typedef enum logic [2:0] {
    SCH_BOOT, SCH_IDLE, SCH_SAVE_WAIT, SCH_LOAD_WAIT, SCH_ERASE_WAIT, SCH_REBOOT
  } sch_state_t;                                 // Handler state

endpackage

// *** logic/sch_reboot_timer.sv ***
// Hold timer for the software reboot window
`timescale 1ns/100ps
module sch_reboot_timer #(
  parameter int REBOOT_CYC = sch_pkg::REBOOT_CYC
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic start,
  output logic      busy,
  output logic      done
);

  logic [31:0] cnt_ff;                           // Cycles left in the window

  // ****************************************
  // Countdown
  // ****************************************
  // Loads on start, counts down to zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= 32'h0;
    end else if (start) begin
      cnt_ff <= 32'(REBOOT_CYC);
    end else if (cnt_ff != 32'h0) begin
      cnt_ff <= cnt_ff - 32'h1;
    end
  end

  // Busy while counting, done in the last cycle
  assign busy = (cnt_ff != 32'h0);
  assign done = (cnt_ff == 32'h1);

endmodule

// *** logic/sch_handler.sv ***
// System command handler: save, restore, reset and amplifier commands
`timescale 1ns/100ps
module sch_handler #(
  parameter int REBOOT_CYC = sch_pkg::REBOOT_CYC
) (
  input  wire logic                          SYS_CLK,
  input  wire logic                          RST,
  input  wire logic                          CMD_VALID,
  output logic                               CMD_READY,
  input  wire sch_pkg::sch_cmd_t             CMD_CODE,
  input  wire logic                          CMD_QUERY,
  input  wire logic                          CMD_HAS_ARG,
  input  wire logic signed [7:0]             CMD_ARG,
  input  wire logic [sch_pkg::PARAM_W-1:0]   WORK_PARAM,
  output logic                               PARAM_LOAD,
  output logic [sch_pkg::PARAM_W-1:0]        PARAM_DATA,
  output logic                               NVM_REQ,
  output logic                               NVM_WRITE,
  output logic [sch_pkg::PARAM_W-1:0]        NVM_WDATA,
  input  wire logic                          NVM_DONE,
  input  wire logic                          NVM_FAIL,
  input  wire logic [sch_pkg::PARAM_W-1:0]   NVM_RDATA,
  output logic                               REPLY_VALID,
  output sch_pkg::sch_rsp_t                  REPLY_KIND,
  output logic [31:0]                        REPLY_VALUE,
  output logic                               AMP_ON,
  output logic                               AMP_KEEP_LIMITS,
  input  wire logic                          AMP_FAULT,
  output logic                               SOFT_RESET_OUT,
  output logic                               USB_DETACH
);

  // ****************************************
  // Declarations
  // ****************************************
  sch_pkg::sch_state_t            state_ff;      // Handler state
  logic                           query_ff;      // Pending command was a query
  logic                           take;          // Command accepted this cycle
  logic                           nvm_end;       // Nonvolatile access finished
  logic                           reboot_start;  // Opens the reboot window
  logic                           reboot_busy;   // Reboot window open
  logic                           reboot_done;   // Last cycle of the window
  logic [7:0]                     last_err_ff;   // Error number for the error query
  logic [sch_pkg::CNT_W-1:0]      user_cnt_ff;   // User memory write count
  logic [sch_pkg::CNT_W-1:0]      cfg_cnt_ff;    // Configuration memory write count
  logic                           is_erase;      // Minus one argument given, command code not decoded
  logic                           amp_arg_ok;    // Amplifier argument in range

  // Accept only when idle, so one command completes first
  assign CMD_READY = (state_ff == sch_pkg::SCH_IDLE);
  assign take      = CMD_VALID & CMD_READY;
  assign nvm_end   = NVM_REQ & NVM_DONE;
  assign is_erase  = CMD_HAS_ARG & (CMD_ARG == sch_pkg::ARG_ERASE);
  assign amp_arg_ok = CMD_QUERY ? (!CMD_HAS_ARG || CMD_ARG == sch_pkg::ARG_ERASE)
                                : (CMD_HAS_ARG && CMD_ARG >= 8'sh00 && CMD_ARG <= 8'sh03);
  assign reboot_start = (take && CMD_CODE == sch_pkg::SCH_RESET) ||
                        (state_ff == sch_pkg::SCH_ERASE_WAIT && nvm_end);

  // ****************************************
  // Reboot window
  // ****************************************
  sch_reboot_timer #(
    .REBOOT_CYC (REBOOT_CYC)
  ) u_reboot (
    .clk   (SYS_CLK),
    .rst   (RST),
    .start (reboot_start),
    .busy  (reboot_busy),
    .done  (reboot_done)
  );

  // Reboot holds the rest of the device and drops USB
  assign SOFT_RESET_OUT = reboot_busy;
  assign USB_DETACH     = reboot_busy;

  // ****************************************
  // Sequencer and nonvolatile port
  // ****************************************
  // Boots by reading stored set, then serves commands
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      state_ff  <= sch_pkg::SCH_BOOT;
      NVM_REQ   <= 1'b1;
      NVM_WRITE <= 1'b0;
      NVM_WDATA <= sch_pkg::PARAM_DEFAULT;
      query_ff  <= 1'b0;
    end else begin
      unique case (state_ff)
        sch_pkg::SCH_BOOT: begin
          // Power-up read of the stored set
          if (nvm_end) begin
            NVM_REQ  <= 1'b0;
            state_ff <= sch_pkg::SCH_IDLE;
          end
        end
        sch_pkg::SCH_IDLE: begin
          if (take) begin
            query_ff <= CMD_QUERY;
            if (CMD_CODE == sch_pkg::SCH_SAVE && !CMD_QUERY) begin
              // Store working set
              NVM_REQ   <= 1'b1;
              NVM_WRITE <= 1'b1;
              NVM_WDATA <= WORK_PARAM;
              state_ff  <= sch_pkg::SCH_SAVE_WAIT;
            end else if (CMD_CODE == sch_pkg::SCH_RESTORE && is_erase && !CMD_QUERY) begin
              // Overwrite stored set with defaults
              NVM_REQ   <= 1'b1;
              NVM_WRITE <= 1'b1;
              NVM_WDATA <= sch_pkg::PARAM_DEFAULT;
              state_ff  <= sch_pkg::SCH_ERASE_WAIT;
            end else if (CMD_CODE == sch_pkg::SCH_RESTORE && !CMD_HAS_ARG) begin
              // Reload without restarting hardware
              NVM_REQ   <= 1'b1;
              NVM_WRITE <= 1'b0;
              state_ff  <= sch_pkg::SCH_LOAD_WAIT;
            end else if (CMD_CODE == sch_pkg::SCH_RESET) begin
              state_ff  <= sch_pkg::SCH_REBOOT;
            end
          end
        end
        sch_pkg::SCH_SAVE_WAIT, sch_pkg::SCH_LOAD_WAIT: begin
          if (nvm_end) begin
            NVM_REQ  <= 1'b0;
            state_ff <= sch_pkg::SCH_IDLE;
          end
        end
        sch_pkg::SCH_ERASE_WAIT: begin
          if (nvm_end) begin
            NVM_REQ  <= 1'b0;
            state_ff <= sch_pkg::SCH_REBOOT;
          end
        end
        sch_pkg::SCH_REBOOT: begin
          // Restart as at power-up
          if (reboot_done) begin
            NVM_REQ   <= 1'b1;
            NVM_WRITE <= 1'b0;
            state_ff  <= sch_pkg::SCH_BOOT;
          end
        end
      endcase
    end
  end

  // ****************************************
  // Parameter load toward the axes
  // ****************************************
  // Pulses with the set read at boot or reload
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      PARAM_LOAD <= 1'b0;
      PARAM_DATA <= sch_pkg::PARAM_DEFAULT;
    end else begin
      PARAM_LOAD <= 1'b0;
      if (nvm_end && !NVM_WRITE) begin
        PARAM_LOAD <= 1'b1;
        // Failed read falls back to defaults
        PARAM_DATA <= NVM_FAIL ? sch_pkg::PARAM_DEFAULT : NVM_RDATA;
      end
    end
  end

  // ****************************************
  // Write-cycle counters
  // ****************************************
  // Count successful writes per memory
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      user_cnt_ff <= sch_pkg::CNT_RESET;
      cfg_cnt_ff  <= sch_pkg::CNT_RESET;
    end else if (nvm_end && !NVM_FAIL) begin
      if (state_ff == sch_pkg::SCH_SAVE_WAIT) begin
        user_cnt_ff <= user_cnt_ff + 16'h1;
      end
      if (state_ff == sch_pkg::SCH_ERASE_WAIT) begin
        cfg_cnt_ff <= cfg_cnt_ff + 16'h1;
      end
    end
  end

  // ****************************************
  // Amplifier control
  // ****************************************
  // Fault wins over any set; reboot switches off from its first cycle
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      AMP_ON          <= 1'b0;
      AMP_KEEP_LIMITS <= 1'b0;
    end else if (AMP_FAULT || reboot_busy || reboot_start) begin
      AMP_ON          <= 1'b0;
      AMP_KEEP_LIMITS <= 1'b0;
    end else if (take && CMD_CODE == sch_pkg::SCH_AMP && !CMD_QUERY && amp_arg_ok) begin
      AMP_ON          <= (CMD_ARG != 8'sh00);
      AMP_KEEP_LIMITS <= (CMD_ARG == 8'sh03);
    end
  end

  // ****************************************
  // Error number
  // ****************************************
  // New error wins over the clear by the error query
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      last_err_ff <= sch_pkg::ERR_NONE;
    end else if (AMP_FAULT) begin
      last_err_ff <= sch_pkg::ERR_AMP;
    end else if (nvm_end && NVM_FAIL) begin
      last_err_ff <= sch_pkg::ERR_NVM;
    end else if (take && CMD_CODE == sch_pkg::SCH_AMP && !amp_arg_ok) begin
      last_err_ff <= sch_pkg::ERR_ARG;
    end else if (take && CMD_CODE == sch_pkg::SCH_RESTORE && CMD_HAS_ARG && !is_erase) begin
      last_err_ff <= sch_pkg::ERR_ARG;
    end else if (take && CMD_CODE == sch_pkg::SCH_ERRQ) begin
      last_err_ff <= sch_pkg::ERR_NONE;
    end
  end

  // ****************************************
  // Replies
  // ****************************************
  // One-cycle reply; silent forms never pulse
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      REPLY_VALID <= 1'b0;
      REPLY_KIND  <= sch_pkg::SCH_RSP_OK;
      REPLY_VALUE <= 32'h0;
    end else begin
      REPLY_VALID <= 1'b0;
      if (state_ff == sch_pkg::SCH_SAVE_WAIT && nvm_end) begin
        // Save answers after the write ends
        REPLY_VALID <= 1'b1;
        REPLY_KIND  <= NVM_FAIL ? sch_pkg::SCH_RSP_ERR : sch_pkg::SCH_RSP_OK;
        REPLY_VALUE <= NVM_FAIL ? {24'h0, sch_pkg::ERR_NVM} : 32'h0;
      end else if (state_ff == sch_pkg::SCH_LOAD_WAIT && nvm_end && query_ff) begin
        // Only the query form of reload answers
        REPLY_VALID <= 1'b1;
        REPLY_KIND  <= NVM_FAIL ? sch_pkg::SCH_RSP_ERR : sch_pkg::SCH_RSP_OK;
        REPLY_VALUE <= NVM_FAIL ? {24'h0, sch_pkg::ERR_NVM} : 32'h0;
      end else if (take) begin
        unique case (CMD_CODE)
          sch_pkg::SCH_SAVE: begin
            if (CMD_QUERY) begin
              REPLY_VALID <= 1'b1;
              REPLY_KIND  <= sch_pkg::SCH_RSP_VAL;
              REPLY_VALUE <= {user_cnt_ff, cfg_cnt_ff};
            end
          end
          sch_pkg::SCH_RESTORE: begin
            if (CMD_QUERY && CMD_HAS_ARG) begin
              REPLY_VALID <= 1'b1;
              REPLY_KIND  <= sch_pkg::SCH_RSP_ERR;
              REPLY_VALUE <= {24'h0, sch_pkg::ERR_ARG};
            end
          end
          sch_pkg::SCH_RESET: begin
            REPLY_VALID <= 1'b0;
          end
          sch_pkg::SCH_AMP: begin
            if (!amp_arg_ok) begin
              REPLY_VALID <= 1'b1;
              REPLY_KIND  <= sch_pkg::SCH_RSP_ERR;
              REPLY_VALUE <= {24'h0, sch_pkg::ERR_ARG};
            end else if (CMD_QUERY) begin
              REPLY_VALID <= 1'b1;
              REPLY_KIND  <= sch_pkg::SCH_RSP_VAL;
              REPLY_VALUE <= {31'h0, AMP_ON};
            end
          end
          sch_pkg::SCH_ERRQ: begin
            // Reachable only once the previous command has ended
            REPLY_VALID <= 1'b1;
            REPLY_KIND  <= sch_pkg::SCH_RSP_VAL;
            REPLY_VALUE <= {24'h0, last_err_ff};
          end
          default: begin
            REPLY_VALID <= 1'b0;
          end
        endcase
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  chk_save_starts_write: assert property (@(posedge SYS_CLK) disable iff (RST)
    take && CMD_CODE == sch_pkg::SCH_SAVE && !CMD_QUERY |=> NVM_REQ && NVM_WRITE && NVM_WDATA == $past(WORK_PARAM))
    else $error("save did not start a write");
  chk_save_reply_ok: assert property (@(posedge SYS_CLK) disable iff (RST)
    state_ff == sch_pkg::SCH_SAVE_WAIT && nvm_end |=> REPLY_VALID && REPLY_KIND == ($past(NVM_FAIL) ?
      sch_pkg::SCH_RSP_ERR : sch_pkg::SCH_RSP_OK))
    else $error("save reply wrong");
  chk_erase_defaults: assert property (@(posedge SYS_CLK) disable iff (RST)
    take && CMD_CODE == sch_pkg::SCH_RESTORE && is_erase && !CMD_QUERY |=> NVM_WDATA == sch_pkg::PARAM_DEFAULT)
    else $error("erase did not write defaults");
  chk_erase_then_reboot: assert property (@(posedge SYS_CLK) disable iff (RST)
    state_ff == sch_pkg::SCH_ERASE_WAIT && nvm_end |=> SOFT_RESET_OUT && !REPLY_VALID)
    else $error("erase not followed by reboot");
  chk_reset_silent: assert property (@(posedge SYS_CLK) disable iff (RST)
    take && CMD_CODE == sch_pkg::SCH_RESET |=> SOFT_RESET_OUT && !REPLY_VALID ##1 !REPLY_VALID)
    else $error("reset answered or did not restart");
  chk_reboot_deaf: assert property (@(posedge SYS_CLK) disable iff (RST)
    SOFT_RESET_OUT |-> !CMD_READY && USB_DETACH)
    else $error("responsive or USB kept during reboot");
  chk_silent_reload: assert property (@(posedge SYS_CLK) disable iff (RST)
    state_ff == sch_pkg::SCH_LOAD_WAIT && nvm_end && !query_ff |=> !REPLY_VALID && PARAM_LOAD)
    else $error("silent restore replied");
  chk_amp_fault: assert property (@(posedge SYS_CLK) disable iff (RST)
    AMP_FAULT |=> !AMP_ON && last_err_ff == sch_pkg::ERR_AMP)
    else $error("fault did not stop amplifiers");
  chk_one_at_a_time: assert property (@(posedge SYS_CLK) disable iff (RST)
    NVM_REQ |-> !CMD_READY)
    else $error("command taken during nonvolatile access");

endmodule

// *** verification/sch_nvm_model.sv ***
// Nonvolatile memory model that answers the handler's access requests
`timescale 1ns/100ps
module sch_nvm_model #(
  parameter logic [31:0] INIT = 32'h1234_5678 // Content found at first power-up
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        req,
  input  wire logic        wr,
  input  wire logic [31:0] wdata,
  input  wire logic [7:0]  lat,
  input  wire logic        fail,
  output logic             done,
  output logic             nfail,
  output logic [31:0]      rdata
);
  // ****************************************
  // Storage and access timing
  // ****************************************
  logic [31:0] mem_ff = INIT; // Stored set, untouched by any reset
  logic [7:0]  cnt_ff;        // Cycles spent on the current access

  // Serve one access after lat cycles, done lasts one cycle
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= 8'h00;
      done   <= 1'h0;
    end else if (done) begin
      done   <= 1'h0;
      cnt_ff <= 8'h00;
    end else if (req && cnt_ff >= lat) begin
      done <= 1'h1;
      if (wr && !fail) mem_ff <= wdata;
    end else if (req) begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end

  // Failure flag only alongside done
  assign nfail = done & fail;
  // Read data valid with done, inverted garbage otherwise
  assign rdata = done ? mem_ff : ~mem_ff;
endmodule

// *** verification/test_sch_handler.sv ***
// Self-checking testbench of the system command handler
`timescale 1ns/100ps
module test_sch_handler;
  // ****************************************
  // Shorthands and case table
  // ****************************************
  localparam sch_pkg::sch_cmd_t c_save = sch_pkg::SCH_SAVE;
  localparam sch_pkg::sch_cmd_t c_rest = sch_pkg::SCH_RESTORE;
  localparam sch_pkg::sch_cmd_t c_boot = sch_pkg::SCH_RESET;
  localparam sch_pkg::sch_cmd_t c_amp  = sch_pkg::SCH_AMP;
  localparam sch_pkg::sch_cmd_t c_errq = sch_pkg::SCH_ERRQ;
  localparam sch_pkg::sch_rsp_t k_ok   = sch_pkg::SCH_RSP_OK;
  localparam sch_pkg::sch_rsp_t k_err  = sch_pkg::SCH_RSP_ERR;
  localparam sch_pkg::sch_rsp_t k_val  = sch_pkg::SCH_RSP_VAL;
  typedef struct packed {
    sch_pkg::sch_cmd_t code; logic q; logic a; logic [7:0] arg;
    sch_pkg::sch_rsp_t kind; logic [31:0] val; logic on; logic keep;
  } sch_row_t; // Command, expected reply (OK marks a silent set) and amplifier state
  sch_row_t rows [13] = '{
    '{c_amp, 1'h0, 1'h1, 8'h01, k_ok, 32'h0, 1'h1, 1'h0}, '{c_amp, 1'h1, 1'h0, 8'h00, k_val, 32'h1, 1'h1, 1'h0},
    '{c_amp, 1'h0, 1'h1, 8'h03, k_ok, 32'h0, 1'h1, 1'h1}, '{c_amp, 1'h1, 1'h1, 8'hff, k_val, 32'h1, 1'h1, 1'h1},
    '{c_amp, 1'h0, 1'h1, 8'h02, k_ok, 32'h0, 1'h1, 1'h0}, '{c_amp, 1'h0, 1'h1, 8'h00, k_ok, 32'h0, 1'h0, 1'h0},
    '{c_amp, 1'h1, 1'h0, 8'h00, k_val, 32'h0, 1'h0, 1'h0}, '{c_amp, 1'h0, 1'h1, 8'h05, k_err, 32'h11, 1'h0, 1'h0},
    '{c_errq, 1'h1, 1'h0, 8'h00, k_val, 32'h11, 1'h0, 1'h0}, '{c_errq, 1'h1, 1'h0, 8'h00, k_val, 32'h0, 1'h0, 1'h0},
    '{c_rest, 1'h1, 1'h1, 8'h05, k_err, 32'h11, 1'h0, 1'h0}, '{c_errq, 1'h1, 1'h0, 8'h00, k_val, 32'h11, 1'h0, 1'h0},
    '{c_save, 1'h1, 1'h0, 8'h00, k_val, 32'h0, 1'h0, 1'h0}};

  // ****************************************
  // Signals
  // ****************************************
  logic                    clk, rst, cmd_valid, cmd_ready, cmd_query, cmd_has_arg;
  sch_pkg::sch_cmd_t       cmd_code;
  logic signed [7:0]       cmd_arg;
  logic [31:0]             work_param, param_data, nvm_wdata, nvm_rdata, reply_value, last_load;
  logic                    param_load, nvm_req, nvm_write, nvm_done, nvm_fail, nvm_bad;
  logic                    reply_valid, amp_on, amp_keep, amp_fault, soft_rst, usb_detach;
  sch_pkg::sch_rsp_t       reply_kind;
  logic [7:0]              nvm_lat;
  int                      mismatches, n_compared, loads, soft_cyc, usb_bad, r, ld;

  sch_handler #(.REBOOT_CYC(20)) sch_handler_i (
    .SYS_CLK(clk), .RST(rst), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_CODE(cmd_code),
    .CMD_QUERY(cmd_query), .CMD_HAS_ARG(cmd_has_arg), .CMD_ARG(cmd_arg), .WORK_PARAM(work_param),
    .PARAM_LOAD(param_load), .PARAM_DATA(param_data), .NVM_REQ(nvm_req), .NVM_WRITE(nvm_write),
    .NVM_WDATA(nvm_wdata), .NVM_DONE(nvm_done), .NVM_FAIL(nvm_fail), .NVM_RDATA(nvm_rdata),
    .REPLY_VALID(reply_valid), .REPLY_KIND(reply_kind), .REPLY_VALUE(reply_value), .AMP_ON(amp_on),
    .AMP_KEEP_LIMITS(amp_keep), .AMP_FAULT(amp_fault), .SOFT_RESET_OUT(soft_rst), .USB_DETACH(usb_detach));
  sch_nvm_model sch_nvm_model_i (
    .clk(clk), .rst(rst), .req(nvm_req), .wr(nvm_write), .wdata(nvm_wdata), .lat(nvm_lat),
    .fail(nvm_bad), .done(nvm_done), .nfail(nvm_fail), .rdata(nvm_rdata));

  // Free-running 50 MHz clock
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  // Counts loads, reboot window length and detach mismatches
  always @(negedge clk) begin
    if (param_load === 1'h1) begin
      loads++;
      last_load = param_data;
    end
    if (soft_rst === 1'h1) soft_cyc++;
    if (usb_detach !== soft_rst) usb_bad++;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic report_and_stop;
    if (mismatches == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Compare and log a mismatch
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Bounded wait for the handler to accept commands
  task automatic wait_ready;
    for (int i = 0; i < 200 && cmd_ready !== 1'h1; i++) @(negedge clk);
    if (cmd_ready !== 1'h1) begin
      mismatches++;
      $display("[FAIL] %0t ready %h exp %h", $time, cmd_ready, 1'h1);
      report_and_stop();
    end
  endtask

  // Offer one command, return at the falling edge after the take
  task automatic send(input sch_pkg::sch_cmd_t c, input logic q, input logic a, input logic [7:0] g);
    @(negedge clk);
    wait_ready();
    cmd_code    = c;
    cmd_query   = q;
    cmd_has_arg = a;
    cmd_arg     = g;
    cmd_valid   = 1'h1;
    @(negedge clk);
    cmd_valid   = 1'h0;
  endtask

  // Bounded wait for one reply pulse, value ignored for OK
  task automatic expect_reply(input sch_pkg::sch_rsp_t k, input logic [31:0] v);
    for (int i = 0; i < 60 && reply_valid !== 1'h1; i++) @(negedge clk);
    check(reply_valid, 1'h1);
    check(reply_kind, k);
    if (k != k_ok) check(reply_value, v);
    if (reply_valid !== 1'h1) report_and_stop();
  endtask

  // No reply pulse for n cycles
  task automatic quiet(input int n);
    logic seen;
    seen = 1'h0;
    for (int i = 0; i < n; i++) begin
      if (reply_valid === 1'h1) seen = 1'h1;
      @(negedge clk);
    end
    check(seen, 1'h0);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {cmd_valid, cmd_query, cmd_has_arg, amp_fault, nvm_bad} = 5'h00;
    {mismatches, n_compared, loads, soft_cyc, usb_bad} = '0;
    cmd_code = c_errq;
    cmd_arg = 8'h00;
    work_param = 32'h0000_0000;
    nvm_lat = 8'h02;
    rst = 1'h1;
    repeat (10) @(negedge clk);
    rst = 1'h0;
    wait_ready();
    @(negedge clk);
    check(last_load, 32'h1234_5678);
    for (r = 0; r < 13; r++) begin
      send(rows[r].code, rows[r].q, rows[r].a, rows[r].arg);
      if (rows[r].kind == k_ok) quiet(2);
      else expect_reply(rows[r].kind, rows[r].val);
      check({amp_on, amp_keep}, {rows[r].on, rows[r].keep});
    end
    // Save with a slow memory, host keeps axes idle
    nvm_lat = 8'h06;
    work_param = 32'h0bad_cafe;
    send(c_save, 1'h0, 1'h0, 8'h00);
    check({nvm_write, cmd_ready}, 2'h2);
    check(nvm_wdata, 32'h0bad_cafe);
    expect_reply(k_ok, 32'h0);
    check(sch_nvm_model_i.mem_ff, 32'h0bad_cafe);
    // Failing save keeps the old image
    nvm_bad = 1'h1;
    work_param = 32'h5555_aaaa;
    send(c_save, 1'h0, 1'h0, 8'h00);
    expect_reply(k_err, 32'h10);
    nvm_bad = 1'h0;
    check(sch_nvm_model_i.mem_ff, 32'h0bad_cafe);
    send(c_errq, 1'h1, 1'h0, 8'h00);
    expect_reply(k_val, 32'h10);
    send(c_save, 1'h1, 1'h0, 8'h00);
    expect_reply(k_val, 32'h0001_0000);
    // Query restore replies and reloads
    ld = loads;
    send(c_rest, 1'h1, 1'h0, 8'h00);
    expect_reply(k_ok, 32'h0);
    @(posedge clk);
    check(loads, ld + 1);
    check(last_load, 32'h0bad_cafe);
    // Silent restore then one error query
    send(c_rest, 1'h0, 1'h0, 8'h00);
    send(c_errq, 1'h1, 1'h0, 8'h00);
    expect_reply(k_val, 32'h0);
    check(loads, ld + 2);
    check(soft_cyc, 0);
    // Amplifier fault
    send(c_amp, 1'h0, 1'h1, 8'h01);
    quiet(2);
    check(amp_on, 1'h1);
    amp_fault = 1'h1;
    @(negedge clk);
    amp_fault = 1'h0;
    check(amp_on, 1'h0);
    send(c_errq, 1'h1, 1'h0, 8'h00);
    expect_reply(k_val, 32'h1d);
    send(c_amp, 1'h1, 1'h0, 8'h00);
    expect_reply(k_val, 32'h0);
    send(c_amp, 1'h0, 1'h1, 8'h01);
    quiet(2);
    check(amp_on, 1'h1);
    // Software reset, then poll until responsive
    ld = loads;
    send(c_boot, 1'h0, 1'h0, 8'h00);
    check({soft_rst, usb_detach, amp_on, cmd_ready}, 4'hc);
    quiet(15);
    // Host reopens its port once the USB link is back
    for (int i = 0; i < 200 && usb_detach !== 1'h0; i++) @(negedge clk);
    check(usb_detach, 1'h0);
    send(c_errq, 1'h1, 1'h0, 8'h00);
    expect_reply(k_val, 32'h0);
    check(soft_cyc, 20);
    check(last_load, 32'h0bad_cafe);
    check(loads, ld + 1);
    // Erase to defaults reboots on its own
    send(c_rest, 1'h0, 1'h1, 8'hff);
    quiet(12);
    check(sch_nvm_model_i.mem_ff, sch_pkg::PARAM_DEFAULT);
    check(soft_rst, 1'h1);
    send(c_errq, 1'h1, 1'h0, 8'h00);
    expect_reply(k_val, 32'h0);
    check(soft_cyc, 40);
    check(usb_bad, 0);
    check(last_load, sch_pkg::PARAM_DEFAULT);
    report_and_stop();
  end
endmodule
